// ===== design/nvram_settings_readback_responder.sv
// Responder for the two stored-settings queries, byte-stream reports
`timescale 1ns/10ps
module nvram_settings_readback_responder
    import nvram_query_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    // Query stream from host
    input  wire logic       rx_valid,
    input  wire rpt_byte_s  rx,
    output logic            rx_ready,
    // Stored settings
    input  wire chip_cfg_s  chip,
    input  wire key_cfg_s   key,
    // Answer stream to host
    output logic            tx_valid,
    output rpt_byte_s       tx,
    input  wire logic       tx_ready,
    // Status
    output logic            query_bad
);

    typedef enum logic [1:0] {S_RECV, S_SEND} state_e;
    typedef enum logic [1:0] {K_NONE, K_CHIP, K_KEY} kind_e;

    state_e            state_q;
    kind_e             kind_q;
    logic [IDX_W-1:0]  ridx_q;
    logic [IDX_W-1:0]  tidx_q;
    logic [7:0]        next_byte;
    logic              rx_take;
    logic              tx_take;
    logic              send_last;
    logic              tx_load;
    logic [IDX_W-1:0]  sent_q;

    assign rx_take   = ce && rx_valid && rx_ready;
    assign tx_take   = ce && tx_valid && tx_ready;
    assign send_last = tidx_q == IX_LAST;
    // Load while answering until the last byte is on the stream
    assign tx_load   = state_q == S_SEND &&
                       (!tx_valid || (tx_ready && !tx.last));

    // ************************************************************
    // Query classification
    // ************************************************************
    function automatic kind_e classify(input kind_e k,
                                       input logic [IDX_W-1:0] i,
                                       input logic [7:0] d);
        kind_e r;
        r = k;
        if (i == IX_CMD) begin
            r = (d == CMD_NVRAM) ? K_CHIP : K_NONE;
        end else if (i == IX_STATUS) begin
            if (k != K_NONE) begin
                r = (d == SUB_CHIP) ? K_CHIP :
                    (d == SUB_KEY)  ? K_KEY  : K_NONE;
            end
        end else if (d != FILL_BYTE) begin
            r = K_NONE;
        end
        return r;
    endfunction

    // ************************************************************
    // Receive side
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ridx_q <= '0;
            kind_q <= K_NONE;
        end else if (rx_take) begin
            kind_q <= classify(kind_q, ridx_q, rx.data);
            ridx_q <= rx.last ? '0 : ridx_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q   <= S_RECV;
            rx_ready  <= 1'b1;
            query_bad <= 1'b0;
        end else if (ce) begin
            unique case (state_q)
                S_RECV: begin
                    if (rx_take && rx.last) begin
                        if (ridx_q == IX_LAST &&
                            classify(kind_q, ridx_q, rx.data) != K_NONE) begin
                            state_q  <= S_SEND;
                            rx_ready <= 1'b0;
                        end else begin
                            query_bad <= 1'b1;
                        end
                    end else if (rx_take) begin
                        query_bad <= 1'b0;
                    end
                end
                S_SEND: begin
                    if (tx_take && tx.last) begin
                        state_q  <= S_RECV;
                        rx_ready <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Answer side
    // ************************************************************
    resp_byte_mux u_mux (
        .is_key (kind_q == K_KEY),
        .idx    (tidx_q),
        .chip   (chip),
        .key    (key),
        .byte_o (next_byte)
    );

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tidx_q   <= '0;
            tx_valid <= 1'b0;
            tx       <= '0;
        end else if (ce) begin
            if (tx_load) begin
                tx_valid  <= 1'b1;
                tx.data   <= next_byte;
                tx.last   <= send_last;
                tidx_q    <= send_last ? '0 : tidx_q + 1'b1;
            end else if (tx_take) begin
                tx_valid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Count of answer bytes taken, for the checks only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sent_q <= '0;
        end else if (tx_take) begin
            sent_q <= tx.last ? '0 : sent_q + 1'b1;
        end
    end

    a_head_cmd: assert property (@(posedge clk) disable iff (!rstn)
        $rose(tx_valid) |-> tx.data == CMD_NVRAM && !tx.last)
        else $error("answer does not start with command echo");

    a_status_ok: assert property (@(posedge clk) disable iff (!rstn)
        tx_take && sent_q == IX_STATUS |-> tx.data == STATUS_OK)
        else $error("status byte not zero");

    a_sub_echo: assert property (@(posedge clk) disable iff (!rstn)
        tx_take && sent_q == IX_SUB && kind_q == K_KEY |-> tx.data == SUB_KEY)
        else $error("key sub-command not echoed");

    a_last_place: assert property (@(posedge clk) disable iff (!rstn)
        tx_take |-> tx.last == (sent_q == IX_LAST))
        else $error("last flag not on byte 63");

    a_last_idx: assert property (@(posedge clk) disable iff (!rstn)
        tx_take && tx.last |=> state_q == S_RECV)
        else $error("answer did not end after last byte");

    a_no_rx_send: assert property (@(posedge clk) disable iff (!rstn)
        state_q == S_SEND |-> !rx_ready)
        else $error("query taken while answering");

    a_hold_data: assert property (@(posedge clk) disable iff (!rstn)
        tx_valid && !tx_ready && ce |=> tx_valid && $stable(tx))
        else $error("answer byte changed under stall");

    a_bad_query: assert property (@(posedge clk) disable iff (!rstn)
        rx_take && rx.last && ridx_q != IX_LAST |=> query_bad)
        else $error("short query not flagged");

    a_key_zero: assert property (@(posedge clk) disable iff (!rstn)
        kind_q == K_KEY && tidx_q > IX_CURRENT |-> next_byte == FILL_BYTE)
        else $error("key answer filler not zero");

    a_opt_bits: assert property (@(posedge clk) disable iff (!rstn)
        kind_q == K_CHIP && tidx_q == IX_OTHER |-> next_byte[7:5] == 3'h0)
        else $error("unused option bits set");

    a_power_low: assert property (@(posedge clk) disable iff (!rstn)
        kind_q == K_KEY && tidx_q == IX_POWER |-> next_byte[4:0] == 5'h00)
        else $error("power low bits set");

    c_chip_ans: cover property (@(posedge clk) disable iff (!rstn)
        tx_take && tx.last && kind_q == K_CHIP);
    c_key_ans: cover property (@(posedge clk) disable iff (!rstn)
        tx_take && tx.last && kind_q == K_KEY);
    c_bad: cover property (@(posedge clk) disable iff (!rstn)
        $rose(query_bad));
    c_stall: cover property (@(posedge clk) disable iff (!rstn)
        tx_valid && !tx_ready && ce);

endmodule

// ===== design/nvram_query_pkg.sv
// Package: report layout and codes for the settings readback responder
package nvram_query_pkg;

    // ************************************************************
    // Report framing
    // ************************************************************
    localparam int         REPORT_BYTES = 64;
    localparam int         IDX_W        = 6;
    localparam logic [7:0] CMD_NVRAM    = 8'h61;
    localparam logic [7:0] SUB_CHIP     = 8'h20;
    localparam logic [7:0] SUB_KEY      = 8'h30;
    localparam logic [7:0] STATUS_OK    = 8'h00;
    localparam logic [7:0] FILL_BYTE    = 8'h00;

    // ************************************************************
    // Byte positions
    // ************************************************************
    localparam logic [5:0] IX_CMD       = 6'h00;
    localparam logic [5:0] IX_STATUS    = 6'h01;
    localparam logic [5:0] IX_SUB       = 6'h02;
    localparam logic [5:0] IX_ROLE7     = 6'h0b;
    localparam logic [5:0] IX_ROLE8     = 6'h0c;
    localparam logic [5:0] IX_OUT_LO    = 6'h0d;
    localparam logic [5:0] IX_OUT_HI    = 6'h0e;
    localparam logic [5:0] IX_DIR_LO    = 6'h0f;
    localparam logic [5:0] IX_DIR_HI    = 6'h10;
    localparam logic [5:0] IX_OTHER     = 6'h11;
    localparam logic [5:0] IX_PROT      = 6'h12;
    localparam logic [5:0] IX_VID_LO    = 6'h0c;
    localparam logic [5:0] IX_VID_HI    = 6'h0d;
    localparam logic [5:0] IX_PID_LO    = 6'h0e;
    localparam logic [5:0] IX_PID_HI    = 6'h0f;
    localparam logic [5:0] IX_POWER     = 6'h1d;
    localparam logic [5:0] IX_CURRENT   = 6'h1e;
    localparam logic [5:0] IX_LAST      = 6'h3f;

    // ************************************************************
    // Field codes
    // ************************************************************
    localparam logic [7:0] ROLE_GPIO    = 8'h00;
    localparam logic [7:0] ROLE_CS      = 8'h01;
    localparam logic [7:0] ROLE_DED     = 8'h02;
    localparam logic [7:0] PROT_NONE    = 8'h00;
    localparam logic [7:0] PROT_PASS    = 8'h40;
    localparam logic [7:0] PROT_LOCK    = 8'h80;
    localparam logic [2:0] CNT_NONE     = 3'h0;
    localparam logic [2:0] CNT_HIGH     = 3'h4;
    localparam int         WAKE_BIT     = 4;
    localparam int         RELEASE_BIT  = 0;
    localparam int         CNT_LO       = 1;
    localparam int         CNT_HI       = 3;
    localparam logic [7:0] POWER_MASK   = 8'he0;

    // Stored power-up chip settings
    typedef struct packed {
        logic [7:0] role_seven;
        logic [7:0] role_eight;
        logic [8:0] out_level;
        logic [8:0] direction;
        logic       wake_en;
        logic [2:0] count_mode;
        logic       keep_bus;
        logic [7:0] protect;
    } chip_cfg_s;

    // Stored USB key parameters
    typedef struct packed {
        logic [15:0] vid;
        logic [15:0] pid;
        logic [7:0]  power;
        logic [7:0]  current;
    } key_cfg_s;

    // One report byte on a stream
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } rpt_byte_s;

endpackage

// ===== design/resp_byte_mux.sv
// Byte selector: one response byte from stored settings by index
`timescale 1ns/10ps
module resp_byte_mux
    import nvram_query_pkg::*;
(
    // Selection
    input  wire logic             is_key,
    input  wire logic [IDX_W-1:0] idx,
    // Stored settings
    input  wire chip_cfg_s        chip,
    input  wire key_cfg_s         key,
    // Result
    output logic [7:0]            byte_o
);

    logic [7:0] other;

    // Other chip settings byte, meaningless bits zero
    always_comb begin
        other              = FILL_BYTE;
        other[WAKE_BIT]    = chip.wake_en;
        other[CNT_HI:CNT_LO] = chip.count_mode;
        other[RELEASE_BIT] = chip.keep_bus;
    end

    always_comb begin
        byte_o = FILL_BYTE;
        if (idx == IX_CMD) begin
            byte_o = CMD_NVRAM;
        end else if (idx == IX_STATUS) begin
            byte_o = STATUS_OK;
        end else if (idx == IX_SUB) begin
            byte_o = is_key ? SUB_KEY : SUB_CHIP;
        end else if (is_key) begin
            unique case (idx)
                IX_VID_LO:  byte_o = key.vid[7:0];
                IX_VID_HI:  byte_o = key.vid[15:8];
                IX_PID_LO:  byte_o = key.pid[7:0];
                IX_PID_HI:  byte_o = key.pid[15:8];
                IX_POWER:   byte_o = key.power & POWER_MASK;
                IX_CURRENT: byte_o = key.current;
                default:    byte_o = FILL_BYTE;
            endcase
        end else begin
            unique case (idx)
                IX_ROLE7:  byte_o = chip.role_seven;
                IX_ROLE8:  byte_o = chip.role_eight;
                IX_OUT_LO: byte_o = chip.out_level[7:0];
                IX_OUT_HI: byte_o = {7'h00, chip.out_level[8]};
                IX_DIR_LO: byte_o = chip.direction[7:0];
                IX_DIR_HI: byte_o = {7'h00, chip.direction[8]};
                IX_OTHER:  byte_o = other;
                IX_PROT:   byte_o = chip.protect;
                default:   byte_o = FILL_BYTE;
            endcase
        end
    end

endmodule

// ===== bench/query_host.sv
// Host model: sends query reports and collects answer reports
`timescale 1ns/10ps
module query_host
    import nvram_query_pkg::*;
(
    // Clock
    input  wire logic      clk,
    // Query stream
    output logic           rx_valid,
    output rpt_byte_s      rx,
    input  wire logic      rx_ready,
    // Answer stream
    input  wire logic      tx_valid,
    input  wire rpt_byte_s tx,
    output logic           tx_ready
);
    logic [7:0] ans [64];
    logic       lst [64];
    int         got;

    initial begin
        rx_valid = 1'b0;
        rx       = '0;
        tx_ready = 1'b0;
    end

    // ************************************************************
    // Send one report, a nonzero byte at bad_ix if in range
    // ************************************************************
    task automatic send(input logic [7:0] sub, input int bad_ix,
                        output bit ok);
        int t;
        ok = 1'b1;
        for (int i = 0; i < REPORT_BYTES; i++) begin
            rx_valid = 1'b1;
            rx.data  = (i == bad_ix) ? 8'h5a     :
                       (i == 0)      ? CMD_NVRAM :
                       (i == 1)      ? sub : 8'h00;
            rx.last  = (i == REPORT_BYTES - 1);
            t = 0;
            // Wait for ready settled before the taking edge
            while (!rx_ready && t < 200) begin
                @(posedge clk);
                #1;
                t++;
            end
            if (!rx_ready) begin
                ok = 1'b0;
            end
            @(posedge clk);
            #1;
        end
        rx_valid = 1'b0;
        rx       = ~rx;
    endtask

    // ************************************************************
    // Collect one answer, stalling every other cycle if slow
    // ************************************************************
    task automatic collect(input bit slow, input int limit,
                           output bit ok);
        int        t;
        bit        take;
        rpt_byte_s seen;
        got      = 0;
        t        = 0;
        tx_ready = 1'b1;
        while (got < REPORT_BYTES && t < limit) begin
            take = tx_valid && tx_ready;
            seen = tx;
            @(posedge clk);
            #1;
            t++;
            if (take) begin
                ans[got] = seen.data;
                lst[got] = seen.last;
                got++;
            end
            if (slow && got < REPORT_BYTES && t < limit) begin
                tx_ready = ~tx_ready;
            end
        end
        tx_ready = 1'b0;
        ok       = (got == REPORT_BYTES);
    endtask
endmodule

// ===== bench/tb_nvram_settings_readback_responder.sv
// Testbench: stored-settings query responder against a host model
`timescale 1ns/10ps
module tb_nvram_settings_readback_responder;
    import nvram_query_pkg::*;

    logic      clk;
    logic      rstn;
    logic      rx_valid;
    rpt_byte_s rx;
    logic      rx_ready;
    chip_cfg_s chip;
    key_cfg_s  key;
    logic      tx_valid;
    rpt_byte_s tx;
    logic      tx_ready;
    logic      query_bad;
    int        errors;
    int        checked;
    bit        ok;

    always #4 clk = ~clk;

    nvram_settings_readback_responder u_nvram_settings_readback_responder (
        .clk(clk), .rstn(rstn), .ce(1'b1), .rx_valid(rx_valid), .rx(rx),
        .rx_ready(rx_ready), .chip(chip), .key(key), .tx_valid(tx_valid),
        .tx(tx), .tx_ready(tx_ready), .query_bad(query_bad));

    query_host u_query_host (
        .clk(clk), .rx_valid(rx_valid), .rx(rx), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready));

    // ************************************************************
    // Expected answer bytes
    // ************************************************************
    function automatic logic [7:0] exp_b(input bit k, input int i);
        if (i == 0) return 8'h61;
        if (i == 2) return k ? 8'h30 : 8'h20;
        if (k) begin
            case (i)
                12: return key.vid[7:0];
                13: return key.vid[15:8];
                14: return key.pid[7:0];
                15: return key.pid[15:8];
                29: return key.power & 8'he0;
                30: return key.current;
                default: return 8'h00;
            endcase
        end
        case (i)
            11: return chip.role_seven;
            12: return chip.role_eight;
            13: return chip.out_level[7:0];
            14: return {7'h00, chip.out_level[8]};
            15: return chip.direction[7:0];
            16: return {7'h00, chip.direction[8]};
            17: return {3'h0, chip.wake_en, chip.count_mode, chip.keep_bus};
            18: return chip.protect;
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] seen);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("Checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic query(input bit k, input bit slow);
        logic [7:0] b;
        u_query_host.send(k ? SUB_KEY : SUB_CHIP, -1, ok);
        if (ok) begin
            u_query_host.collect(slow, 400, ok);
        end
        if (!ok) begin
            errors++;
            $display("Error answer count expected 64 seen %0d",
                     u_query_host.got);
        end else begin
            for (int i = 0; i < REPORT_BYTES; i++) begin
                b = u_query_host.ans[i];
                check($sformatf("byte %0d", i), exp_b(k, i), b);
                check("last", {7'h0, i == 63}, {7'h0, u_query_host.lst[i]});
            end
        end
        check("query_bad", 8'h00, {7'h0, query_bad});
    endtask

    initial begin
        clk     = 1'b0;
        rstn    = 1'b0;
        errors  = 0;
        checked = 0;
        chip    = '{8'h02, 8'h01, 9'h1a5, 9'h13c, 1'b1, 3'h3, 1'b1, 8'h40};
        key     = '{16'hbeef, 16'h1234, 8'hff, 8'h32};
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        check("rx_ready", 8'h01, {7'h0, rx_ready});
        query(1'b0, 1'b0);
        $display("Test chip answer done");
        query(1'b1, 1'b1);
        $display("Test key answer under stall done");
        // All counting, role and protection codes
        for (int m = 0; m < 8; m++) begin
            chip.count_mode = m[2:0];
            chip.role_seven = 8'(m % 3);
            chip.role_eight = 8'((m + 1) % 3);
            chip.protect    = 8'(m % 3) << 6;
            chip.wake_en    = m[0];
            chip.keep_bus   = m[1];
            chip.out_level  = 9'h100 >> m;
            chip.direction  = ~(9'h001 << m);
            query(1'b0, m[0]);
        end
        $display("Test field codes done");
        // Unknown sub-command, nonzero reserved bytes
        for (int b = 0; b < 3; b++) begin
            u_query_host.send(SUB_CHIP, b == 2 ? 63 : b + 1, ok);
            u_query_host.collect(1'b0, 100, ok);
            check("answer count", 8'h00, 8'(u_query_host.got));
            check("query_bad", 8'h01, {7'h0, query_bad});
        end
        query(1'b1, 1'b0);
        $display("Test malformed queries done");
        results();
    end
endmodule
